// ==== rtl/etsr_pkg.sv ====
package etsr_pkg;

    // ------------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------------
    localparam logic [11:0] ETSR_OFS_UNIT_INDEX = 12'h500;
    localparam logic [11:0] ETSR_OFS_CAP_CTRL = 12'h504;
    localparam logic [11:0] ETSR_OFS_CAP_STATUS = 12'h508;
    localparam logic [11:0] ETSR_OFS_S3_NSEC = 12'h56c;
    localparam logic [11:0] ETSR_OFS_S3_SEC = 12'h570;
    localparam logic [11:0] ETSR_OFS_S3_PHASE = 12'h574;
    localparam logic [11:0] ETSR_OFS_S4_NSEC = 12'h578;
    localparam logic [11:0] ETSR_OFS_S4_SEC = 12'h57c;
    localparam logic [11:0] ETSR_OFS_S4_PHASE = 12'h580;
    localparam logic [11:0] ETSR_OFS_S5_NSEC = 12'h584;
    localparam logic [11:0] ETSR_OFS_S5_SEC = 12'h588;
    localparam logic [11:0] ETSR_OFS_S5_PHASE = 12'h58c;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int unsigned ETSR_NSEC_POL_BIT = 30;
    localparam int unsigned ETSR_NSEC_W = 30;
    localparam int unsigned ETSR_SEC_W = 32;
    localparam int unsigned ETSR_PHASE_W = 3;
    localparam int unsigned ETSR_UNIT_PTR_BIT = 8;
    localparam int unsigned ETSR_STATUS_CNT_W = 3;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [31:0] ETSR_RST_WORD = 32'h0000_0000;
    localparam logic [29:0] ETSR_RST_NSEC = 30'h0000_0000;
    localparam logic [31:0] ETSR_RST_SEC = 32'h0000_0000;
    localparam logic [2:0] ETSR_RST_PHASE = 3'h0;
    localparam logic [2:0] ETSR_RST_CNT = 3'h0;

    // ------------------------------------------------------------------
    // Sample sequence and timing
    // ------------------------------------------------------------------
    localparam logic [2:0] ETSR_FIRST_KEPT = 3'h3;
    localparam logic [2:0] ETSR_LAST_KEPT = 3'h5;
    localparam int unsigned ETSR_KEPT_SAMPLES = 3;
    localparam logic [2:0] ETSR_CNT_SAT = 3'h6;
    localparam int unsigned ETSR_SLOT_NS = 8;
    localparam int unsigned ETSR_REF_PERIOD_NS = 40;
    localparam int unsigned ETSR_SLOTS = ETSR_REF_PERIOD_NS / ETSR_SLOT_NS;
    localparam int unsigned ETSR_SYNC_STAGES = 3;

    // Phase codes for the 8 ns slot inside one reference period
    typedef enum logic [2:0] {
        ETSR_PH_0NS = 3'b000,
        ETSR_PH_8NS = 3'b001,
        ETSR_PH_16NS = 3'b010,
        ETSR_PH_24NS = 3'b011,
        ETSR_PH_32NS = 3'b100
    } etsr_phase_t;

endpackage : etsr_pkg

// ==== rtl/etsr_phase_enc.sv ====
`timescale 1ns/10ps
module etsr_phase_enc
    import etsr_pkg::*;
(
    input wire logic [2:0] slot_i,
    output etsr_phase_t code_o
);

    // ------------------------------------------------------------------
    // Slot to phase code
    // ------------------------------------------------------------------
    // Out-of-range slots clamp to the last slot, never a reserved code
    always_comb begin
        case (slot_i)
            3'h0: code_o = ETSR_PH_0NS;
            3'h1: code_o = ETSR_PH_8NS;
            3'h2: code_o = ETSR_PH_16NS;
            3'h3: code_o = ETSR_PH_24NS;
            3'h4: code_o = ETSR_PH_32NS;
            default: code_o = ETSR_PH_32NS;
        endcase
    end

endmodule : etsr_phase_enc

// ==== rtl/etsr_readout.sv ====
// Register access over Wishbone was left to the implementer.
`timescale 1ns/10ps
// Notes on behaviour
// - Each sample keeps a 3-bit code naming its 8 ns slot in 40 ns.
// - Codes: 000 is 0 ns, 001 is 8 ns, 011 is 24 ns, 100 is 32 ns.
// - The 16 ns slot reads 010; codes 101 to 111 never appear.
// - Nanoseconds bit 30 shows edge polarity, one rising, zero falling.
// - Nanoseconds bits 29 to 0 hold the capture nanoseconds.
// - Seconds register holds the full 32-bit capture seconds.
// - Sample registers show the unit picked by index pointer bit 8.
// - Third, fourth and fifth samples each keep their own result set.
module etsr_readout
    import etsr_pkg::*;
#(
    parameter int unsigned NUM_UNITS = 2
) (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [11:2] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [NUM_UNITS-1:0] evt_in_i,
    input wire logic [3*NUM_UNITS-1:0] evt_slot_i,
    input wire logic [31:0] tod_sec_i,
    input wire logic [29:0] tod_nsec_i
);

    // ------------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------------
    // The pointer is a single bit, so at most two units can be reached
    if (NUM_UNITS < 1 || NUM_UNITS > 2) begin : g_bad_units
        $error("etsr_readout: NUM_UNITS must be 1 or 2");
    end

    // Three result sets are mapped; the counter must saturate right
    // after the last kept sample, or a late edge would overwrite one
    if (ETSR_KEPT_SAMPLES != 3 ||
        ETSR_LAST_KEPT + 3'h1 != ETSR_CNT_SAT) begin : g_bad_window
        $error("etsr_readout: kept window must end below saturation");
    end

    // The encoder knows five 8 ns slots; another period needs new codes
    if (ETSR_SLOTS != 5 || ETSR_PHASE_W != 3) begin : g_bad_slots
        $error("etsr_readout: slot layout does not match the encoder");
    end

    // Edge detection compares stages two and three of three
    if (ETSR_SYNC_STAGES != 3) begin : g_bad_sync
        $error("etsr_readout: synchroniser must have three stages");
    end

    // Polarity sits right above the nanoseconds, bit 31 stays reserved
    if (ETSR_NSEC_POL_BIT != ETSR_NSEC_W) begin : g_bad_nsec
        $error("etsr_readout: polarity must sit above the nanoseconds");
    end

    // The first edge after a restart must count as sample one
    if (ETSR_RST_CNT != 3'h0) begin : g_bad_first
        $error("etsr_readout: sample count must restart from zero");
    end

    // Word offsets only; the low address bits are not on the bus
    if (ETSR_OFS_S3_NSEC[1:0] != 2'b00 ||
        ETSR_OFS_S5_PHASE[1:0] != 2'b00) begin : g_bad_ofs
        $error("etsr_readout: register offsets must be word aligned");
    end

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    logic unit_ptr_q;
    logic [11:0] byte_adr;
    logic bus_req;
    logic bus_wr;
    logic [31:0] rd_word;
    logic [NUM_UNITS-1:0] restart;
    logic sel_unit;
    logic wr_index;
    logic wr_ctrl;
    logic [1:0] fill_q;
    logic sync_full;
    logic [31:0] index_word;
    logic [31:0] status_word;

    // Per-unit capture state
    logic [NUM_UNITS-1:0] sync1_q;
    logic [NUM_UNITS-1:0] sync2_q;
    logic [NUM_UNITS-1:0] sync3_q;
    logic [NUM_UNITS-1:0] level_q;
    logic [NUM_UNITS-1:0] primed_q;
    logic [NUM_UNITS-1:0] edge_seen;
    logic [NUM_UNITS-1:0] edge_rise;
    logic [2:0] cnt_q [NUM_UNITS];
    etsr_phase_t slot_code [NUM_UNITS];
    logic [ETSR_KEPT_SAMPLES-1:0] store_en [NUM_UNITS];

    // Result memory: one set per unit and per kept sample
    logic [31:0] sec_q [NUM_UNITS][ETSR_KEPT_SAMPLES];
    logic [29:0] nsec_q [NUM_UNITS][ETSR_KEPT_SAMPLES];
    logic pol_q [NUM_UNITS][ETSR_KEPT_SAMPLES];
    logic [2:0] phase_q [NUM_UNITS][ETSR_KEPT_SAMPLES];

    // Selected unit's result words, reserved bits already cleared
    logic [31:0] nsec_word [ETSR_KEPT_SAMPLES];
    logic [31:0] sec_word [ETSR_KEPT_SAMPLES];
    logic [31:0] phase_word [ETSR_KEPT_SAMPLES];

    // ------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------
    // Request stands while the master waits; ack masks the second edge
    assign byte_adr = {wb_adr_i, 2'b00};
    assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign bus_wr = bus_req & wb_we_i;

    // Write strobes of the two writable words; sample words ignore writes
    assign wr_index = bus_wr && byte_adr == ETSR_OFS_UNIT_INDEX &&
                      wb_sel_i[1];
    assign wr_ctrl = bus_wr && byte_adr == ETSR_OFS_CAP_CTRL && wb_sel_i[0];

    // A pointer beyond the fitted units falls back to unit zero
    assign sel_unit = (unit_ptr_q && NUM_UNITS > 1) ? 1'b1 : 1'b0;

    // Restart strobes, one per unit, from the control register
    always_comb begin
        restart = '0;
        if (wr_ctrl) begin
            restart = wb_dat_i[NUM_UNITS-1:0];
        end
    end

    // ------------------------------------------------------------------
    // Unit index pointer
    // ------------------------------------------------------------------
    // Only the pointer bit is writable; other bits of the word read zero
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            unit_ptr_q <= 1'b0;
        end else if (wr_index) begin
            unit_ptr_q <= wb_dat_i[ETSR_UNIT_PTR_BIT];
        end
    end

    // ------------------------------------------------------------------
    // Synchroniser fill after reset
    // ------------------------------------------------------------------
    // The stages leave reset at zero, not at the pin's level. The settled
    // level is first taken once every stage holds a real pin sample, so
    // a pin that is already high at reset is never seen as a rising edge
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            fill_q <= 2'h0;
        end else if (!sync_full) begin
            fill_q <= fill_q + 2'h1;
        end
    end

    // Shared by all units; they leave reset together
    assign sync_full = (fill_q == 2'(ETSR_SYNC_STAGES));

    // ------------------------------------------------------------------
    // Per-unit event capture
    // ------------------------------------------------------------------
    // Each unit has its own synchroniser, counter and three result sets
    for (genvar u = 0; u < NUM_UNITS; u++) begin : g_unit

        // Three-stage synchroniser on the event pin
        always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
                sync1_q[u] <= 1'b0;
                sync2_q[u] <= 1'b0;
                sync3_q[u] <= 1'b0;
            end else begin
                sync1_q[u] <= evt_in_i[u];
                sync2_q[u] <= sync1_q[u];
                sync3_q[u] <= sync2_q[u];
            end
        end

        // A change counts once the last two stages agree
        assign edge_seen[u] = primed_q[u] & (sync2_q[u] == sync3_q[u]) &
                              (sync2_q[u] != level_q[u]);
        assign edge_rise[u] = sync2_q[u];

        // Settled level; the first agreement once the stages are full
        // only primes it, so the pin's level at reset is never an edge
        always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
                level_q[u] <= 1'b0;
                primed_q[u] <= 1'b0;
            end else if (sync_full && sync2_q[u] == sync3_q[u]) begin
                level_q[u] <= sync2_q[u];
                primed_q[u] <= 1'b1;
            end
        end

        // Slot of the edge inside the reference period
        etsr_phase_enc u_phase_enc (
            .slot_i (evt_slot_i[3*u +: 3]),
            .code_o (slot_code[u])
        );

        // Sample counter; an edge in the restart cycle is sample one
        always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
                cnt_q[u] <= ETSR_RST_CNT;
            end else if (restart[u]) begin
                cnt_q[u] <= edge_seen[u] ? 3'h1 : ETSR_RST_CNT;
            end else if (edge_seen[u] && cnt_q[u] != ETSR_CNT_SAT) begin
                cnt_q[u] <= cnt_q[u] + 3'h1;
            end
        end

        // Result sets for the third, fourth and fifth samples
        for (genvar k = 0; k < ETSR_KEPT_SAMPLES; k++) begin : g_slot
            localparam logic [2:0] SAMPLE_NO = ETSR_FIRST_KEPT + 3'(k);

            // Counter still holds the previous count in the edge cycle;
            // an edge in a restart cycle is sample one and is not kept
            assign store_en[u][k] = edge_seen[u] && !restart[u] &&
                                    cnt_q[u] + 3'h1 == SAMPLE_NO;

            always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    sec_q[u][k] <= ETSR_RST_SEC;
                    nsec_q[u][k] <= ETSR_RST_NSEC;
                    pol_q[u][k] <= 1'b0;
                    phase_q[u][k] <= ETSR_RST_PHASE;
                end else if (store_en[u][k]) begin
                    sec_q[u][k] <= tod_sec_i;
                    nsec_q[u][k] <= tod_nsec_i;
                    pol_q[u][k] <= edge_rise[u];
                    phase_q[u][k] <= slot_code[u];
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Result words of the selected unit
    // ------------------------------------------------------------------
    // Words are built whole, so the multiplexer below only picks one and
    // no reserved bit can leak through a partial assignment
    for (genvar k = 0; k < ETSR_KEPT_SAMPLES; k++) begin : g_word
        always_comb begin
            nsec_word[k] = ETSR_RST_WORD;
            nsec_word[k][ETSR_NSEC_POL_BIT] = pol_q[sel_unit][k];
            nsec_word[k][ETSR_NSEC_W-1:0] = nsec_q[sel_unit][k];
        end

        // Seconds use the whole word
        assign sec_word[k] = sec_q[sel_unit][k];

        // Phase code in the low bits, the rest reads zero
        always_comb begin
            phase_word[k] = ETSR_RST_WORD;
            phase_word[k][ETSR_PHASE_W-1:0] = phase_q[sel_unit][k];
        end
    end

    // Pointer readback; all other bits of the index word read zero
    always_comb begin
        index_word = ETSR_RST_WORD;
        index_word[ETSR_UNIT_PTR_BIT] = unit_ptr_q;
    end

    // Edge count of the selected unit, saturating at six
    always_comb begin
        status_word = ETSR_RST_WORD;
        status_word[ETSR_STATUS_CNT_W-1:0] = cnt_q[sel_unit];
    end

    // ------------------------------------------------------------------
    // Read multiplexer
    // ------------------------------------------------------------------
    // Unmapped addresses read zero and are still acknowledged
    always_comb begin
        rd_word = ETSR_RST_WORD;
        case (byte_adr)
            ETSR_OFS_UNIT_INDEX: begin
                rd_word = index_word;
            end
            ETSR_OFS_CAP_STATUS: begin
                rd_word = status_word;
            end
            ETSR_OFS_S3_NSEC: begin
                rd_word = nsec_word[0];
            end
            ETSR_OFS_S3_SEC: begin
                rd_word = sec_word[0];
            end
            ETSR_OFS_S3_PHASE: begin
                rd_word = phase_word[0];
            end
            ETSR_OFS_S4_NSEC: begin
                rd_word = nsec_word[1];
            end
            ETSR_OFS_S4_SEC: begin
                rd_word = sec_word[1];
            end
            ETSR_OFS_S4_PHASE: begin
                rd_word = phase_word[1];
            end
            ETSR_OFS_S5_NSEC: begin
                rd_word = nsec_word[2];
            end
            ETSR_OFS_S5_SEC: begin
                rd_word = sec_word[2];
            end
            ETSR_OFS_S5_PHASE: begin
                rd_word = phase_word[2];
            end
            default: begin
                rd_word = ETSR_RST_WORD;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // Bus answer
    // ------------------------------------------------------------------
    // One-cycle ack; writes to sample registers are simply dropped
    // A strobe held past the ack is answered again every other cycle
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= bus_req;
        end
    end

    // Read data is registered with the ack, held until the next read
    // Registered so that the read path adds no logic after the flops
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wb_dat_o <= ETSR_RST_WORD;
        end else if (bus_req && !wb_we_i) begin
            wb_dat_o <= rd_word;
        end
    end

endmodule : etsr_readout

// ==== test/etsr_readout_monitor.sv ====
`timescale 1ns/10ps
module etsr_readout_monitor
    import etsr_pkg::*;
#(
    parameter int unsigned NUM_UNITS = 2
) (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [11:2] wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o
);
    // Read completions by register kind; address is still held at ack
    logic rd, rd_ph, rd_ns;
    assign rd = wb_ack_o && !wb_we_i;
    assign rd_ph = rd && (wb_adr_i == ETSR_OFS_S3_PHASE[11:2]
        || wb_adr_i == ETSR_OFS_S4_PHASE[11:2]
        || wb_adr_i == ETSR_OFS_S5_PHASE[11:2]);
    assign rd_ns = rd && (wb_adr_i == ETSR_OFS_S3_NSEC[11:2]
        || wb_adr_i == ETSR_OFS_S4_NSEC[11:2]
        || wb_adr_i == ETSR_OFS_S5_NSEC[11:2]);
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!rst_n_i);
    property p_ack_resp; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
    endproperty
    a_ack_resp: assert property (p_ack_resp)
        else $error("request not acked next cycle");
    property p_ack_one; wb_ack_o |=> !wb_ack_o; endproperty
    a_ack_one: assert property (p_ack_one)
        else $error("ack longer than one cycle");
    property p_no_ack; !(wb_cyc_i && wb_stb_i) |=> !wb_ack_o; endproperty
    a_no_ack: assert property (p_no_ack)
        else $error("ack without request");
    property p_dat_hold; !rd |-> $stable(wb_dat_o); endproperty
    a_dat_hold: assert property (p_dat_hold)
        else $error("read data moved outside a read");
    property p_ph_code; rd_ph |-> wb_dat_o <= 32'h4; endproperty
    a_ph_code: assert property (p_ph_code)
        else $error("phase word holds a reserved value");
    property p_ns_resv; rd_ns |-> !wb_dat_o[31]; endproperty
    a_ns_resv: assert property (p_ns_resv)
        else $error("nanoseconds top bit set");
    property p_rst_zero; $rose(rst_n_i) |-> !wb_ack_o && wb_dat_o == 0;
    endproperty
    a_rst_zero: assert property (p_rst_zero)
        else $error("outputs not clear after reset");
    property p_unmapped; rd && wb_adr_i == 10'h1ff |-> wb_dat_o == 0;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped word not zero");
endmodule : etsr_readout_monitor
bind etsr_readout etsr_readout_monitor #(.NUM_UNITS(NUM_UNITS)) u_mon (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));

// ==== test/etsr_event_src.sv ====
`timescale 1ns/10ps
module etsr_event_src (
    input wire logic clk_i,
    output logic [1:0] evt_o,
    output logic [5:0] slot_o
);
    initial begin
        evt_o = 2'h0;
        slot_o = 6'h2a;
    end
    // Slot held until the edge is long seen, then scrambled so that a
    // late capture shows up as a wrong phase
    task automatic fire(input int u, input logic lvl, input logic [2:0] sl);
        @(posedge clk_i);
        evt_o[u] <= lvl;
        slot_o[3*u +: 3] <= sl;
        repeat (8) @(posedge clk_i);
        slot_o[3*u +: 3] <= ~sl;
    endtask : fire
endmodule : etsr_event_src

// ==== test/etsr_readout_tb_top.sv ====
`timescale 1ns/10ps
module etsr_readout_tb_top;
    import etsr_pkg::*;
    typedef struct {
        logic [2:0] slot;
        logic [31:0] sec;
        logic [29:0] ns;
        logic [2:0] code;
    } etsr_row_t;
    logic clk_sys_i = 1'b0, rst_n_i = 1'b0;
    logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o;
    logic [9:0] wb_adr_i = 10'h0;
    logic [3:0] wb_sel_i = 4'hf;
    logic [31:0] wb_dat_i = 32'h0, tod_sec_i = 32'h0, wb_dat_o, rd;
    logic [29:0] tod_nsec_i = 30'h0;
    logic [1:0] evt;
    logic [5:0] slot;
    int fail_count = 0, n_compared = 0;
    // Five edges per unit; the third to fifth are the kept ones.
    // Slot 7 is out of range and must read as the last slot.
    etsr_row_t rows [10] = '{
        '{3'h0, 32'h0000_0010, 30'h0000_0010, 3'h0},
        '{3'h1, 32'h0000_0020, 30'h0000_0020, 3'h1},
        '{3'h7, 32'hffff_ffff, 30'h3fff_ffff, 3'h4},
        '{3'h3, 32'h1234_5678, 30'h0555_5555, 3'h3},
        '{3'h4, 32'h8000_0001, 30'h2aaa_aaaa, 3'h4},
        '{3'h4, 32'h0000_0050, 30'h0000_0050, 3'h4},
        '{3'h3, 32'h0000_0060, 30'h0000_0060, 3'h3},
        '{3'h0, 32'h0000_0001, 30'h0000_0000, 3'h0},
        '{3'h1, 32'h7654_3210, 30'h1000_0001, 3'h1},
        '{3'h2, 32'h00ab_cdef, 30'h0123_4567, 3'h2}};
    always #50 clk_sys_i = ~clk_sys_i;
    etsr_readout #(.NUM_UNITS(2)) dut (.clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .evt_in_i(evt), .evt_slot_i(slot), .tod_sec_i(tod_sec_i),
        .tod_nsec_i(tod_nsec_i));
    etsr_event_src u_src (.clk_i(clk_sys_i), .evt_o(evt), .slot_o(slot));
    // ----------------------------------------
    // Checking and bus tasks
    // ----------------------------------------
    task automatic chk(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            $display("ERROR %s expected %h seen %h", what, exp, seen);
            fail_count++;
        end
    endtask : chk
    task automatic conclude();
        $display("Compared %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : conclude
    // Classic cycle; request held until ack is sampled high
    task automatic wb(input logic we, input logic [11:0] a,
                      input logic [31:0] wd);
        int n;
        @(posedge clk_sys_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a[11:2];
        wb_dat_i <= wd;
        for (n = 0; n < 20; n++) begin
            @(posedge clk_sys_i);
            if (wb_ack_o === 1'b1) break;
        end
        if (n == 20) begin
            fail_count++;
            conclude();
        end
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask : wb
    task automatic rdchk(input string what, input logic [11:0] a,
                         input logic [31:0] exp);
        wb(1'b0, a, 32'h0);
        chk(what, rd, exp);
    endtask : rdchk
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        int r, u, k;
        logic [11:0] a;
        repeat (20) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        for (a = ETSR_OFS_S3_NSEC; a <= ETSR_OFS_S5_PHASE; a += 12'h4) begin
            rdchk("reset value", a, 32'h0);
        end
        rdchk("unmapped", 12'h7fc, 32'h0);
        // Time of day held steady across each edge so captures are exact
        for (r = 0; r < 10; r++) begin
            tod_sec_i <= rows[r].sec;
            tod_nsec_i <= rows[r].ns;
            u_src.fire(r / 5, (r % 5) % 2 == 0, rows[r].slot);
        end
        for (u = 0; u < 2; u++) begin
            wb(1'b1, ETSR_OFS_UNIT_INDEX, 32'(u) << 8);
            for (k = 2; k < 5; k++) begin
                r = u * 5 + k;
                a = ETSR_OFS_S3_NSEC + 12'(12 * (k - 2));
                rdchk("nsec", a, {1'b0, k % 2 == 0, rows[r].ns});
                rdchk("sec", a + 12'h4, rows[r].sec);
                rdchk("phase", a + 12'h8, {29'h0, rows[r].code});
            end
        end
        rdchk("index", ETSR_OFS_UNIT_INDEX, 32'h0000_0100);
        rdchk("count", ETSR_OFS_CAP_STATUS, 32'h5);
        // Writes must not reach a sample
        wb(1'b1, ETSR_OFS_S4_SEC, 32'hffff_0000);
        rdchk("written sec", ETSR_OFS_S4_SEC, rows[8].sec);
        // A sixth edge is not stored over the fifth
        wb(1'b1, ETSR_OFS_UNIT_INDEX, 32'h0);
        tod_sec_i <= 32'h5555_5555;
        u_src.fire(0, 1'b0, 3'h1);
        rdchk("sixth edge", ETSR_OFS_S5_SEC, rows[4].sec);
        rdchk("saturated", ETSR_OFS_CAP_STATUS, 32'(ETSR_CNT_SAT));
        // Restart clears the count only, kept samples stay
        wb(1'b1, ETSR_OFS_CAP_CTRL, 32'h1);
        rdchk("restarted", ETSR_OFS_CAP_STATUS, 32'h0);
        rdchk("kept", ETSR_OFS_S5_SEC, rows[4].sec);
        // Reset in mid-run clears kept samples
        rst_n_i <= 1'b0;
        repeat (2) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        rdchk("after reset", ETSR_OFS_S4_NSEC, 32'h0);
        // Unit one's pin stayed high through reset: no edge may be seen
        wb(1'b1, ETSR_OFS_UNIT_INDEX, 32'h0000_0100);
        rdchk("pin high at reset", ETSR_OFS_CAP_STATUS, 32'h0);
        conclude();
    end
endmodule : etsr_readout_tb_top
